// ===== core/bus_command_input_processor.sv
// input command path of a bus-attached measuring instrument
// assumes: bus listener logic on core_clk offers bytes with rxValid/rxReady;
// measurement, status formatting and configuration engines sit outside
`timescale 1ns/1ps
`default_nettype none
`include "cmd_input_cfg.svh"

// Function
// - single trigger only in external trigger modes
// - single trigger measures once into output
// - only single trigger and GET get queued
// - store 350 chars, execute on terminator/full
// - terminators are CR, LF, GET, EOI
// - execute in order, free space per character
// - full buffer holds off until strings executed
// - upper and lower case are equivalent
// - drop spaces, commas, control codes
// - terminator group stores a single terminator; a GET marker is stored even right after another terminator
// - numeric arguments in NR1, NR2, NR3
// - illegal command loads error, config unchanged
// - output cleared after read, continuous excepted; the code clears it in continuous mode too, until the next reading loads it
// - one output buffer, last output wins
// - read or new terminator drops data available
// - queries, trigger, continuous, GET load output
// - data available is poll bit five
// - finish input before loading output, set available
// - new input string clears poll byte
module bus_command_input_processor
  import cmd_input_pkg::*;
#(
  parameter int DEPTH = `CMD_BUF_DEPTH,
  parameter int VW = `CMD_VAL_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEoi,
  input wire logic rxGet,
  output logic rxReady,
  input wire logic busClear,
  output logic execValid,
  output logic [7:0] execChar,
  input wire logic execIllegal,
  output logic [2:0] trigMode,
  output logic measReq,
  input wire logic measDone,
  input wire logic [VW-1:0] measValue,
  input wire logic contReading,
  input wire logic talkBusy,
  output logic [3:0] statusSel,
  input wire logic [VW-1:0] statusData,
  output logic outValid,
  output logic [VW-1:0] outData,
  output logic outIsError,
  input wire logic readDone,
  output logic [7:0] spollByte
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    exec_state_t state;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic [CW-1:0] termCount;
    logic holdOff;
    logic lastTerm;
    logic pendEoi;
    logic commitAfter;
    logic [7:0] curLetter;
    logic [2:0] trigMode;
    logic pendStat;
    logic pendErr;
    logic pendNum;
    logic [VW-1:0] statVal;
    logic [VW-1:0] numVal;
    logic dataAvail;
    logic anyError;
    logic outIsError;
    logic [VW-1:0] outData;
    logic execValid;
    logic [7:0] execChar;
    logic measReq;
  } core_state_t;

  core_state_t s_reg, s_next;
  logic isTerm, isDiscard;
  logic [7:0] normChar, rdChar;
  logic accept, wrEn, rdEn, termIn;
  logic [7:0] wrData;

  cmd_char_filter u_filter (
    .rawChar(rxData),
    .isTerm(isTerm),
    .isDiscard(isDiscard),
    .normChar(normChar)
  );

  cmd_char_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrAddr(s_reg.wrPtr),
    .wrData(wrData),
    .rdEn(rdEn),
    .rdAddr(s_reg.rdPtr),
    .rdData(rdChar)
  );

  // stall the talker instead of dropping bytes
  assign rxReady = !s_reg.holdOff && !s_reg.pendEoi && !busClear;
  assign accept = (rxValid || rxGet) && rxReady;

  // entry side: what is written into the buffer this cycle
  always_comb begin
    wrEn = 1'b0;
    wrData = `MARK_TERM;
    termIn = 1'b0;
    if (s_reg.pendEoi) begin
      // EOI came with a real character, its terminator follows here
      wrEn = s_reg.count != FULL;
      termIn = wrEn;
    end else if (accept && rxGet) begin
      wrEn = 1'b1; // group trigger is queued as a marker
      wrData = `MARK_GET;
      termIn = 1'b1;
    end else if (accept && (isTerm || (rxEoi && isDiscard))) begin
      wrEn = !s_reg.lastTerm;
      termIn = 1'b1;
    end else if (accept && !isDiscard) begin
      wrEn = 1'b1;
      wrData = normChar;
    end
  end

  assign rdEn = (s_reg.state == EX_IDLE) && (s_reg.count != '0) &&
    ((s_reg.termCount != '0) || s_reg.holdOff);
  // holdOff alone drains a full buffer that holds no terminator yet

  // next state of the whole block
  always_comb begin
    logic consume;
    logic isMark;
    logic commit;
    logic [CW-1:0] cnt;
    logic [CW-1:0] tcnt;
    logic pStat;
    logic pErr;
    logic pNum;
    s_next = s_reg;
    consume = 1'b0;
    isMark = 1'b0;
    commit = 1'b0;
    cnt = s_reg.count;
    tcnt = s_reg.termCount;
    // pending flags as they stand once this cycle's work is in
    pStat = 1'b0;
    pErr = 1'b0;
    pNum = 1'b0;
    s_next.execValid = 1'b0;
    s_next.measReq = 1'b0;

    // write side bookkeeping
    if (wrEn) begin
      s_next.wrPtr = (s_reg.wrPtr == LAST) ? '0 : s_reg.wrPtr + 1'b1;
      cnt = cnt + 1'b1;
      if (wrData == `MARK_TERM || wrData == `MARK_GET) begin
        tcnt = tcnt + 1'b1;
      end
    end
    if (s_reg.pendEoi) begin
      s_next.pendEoi = !wrEn;
      s_next.lastTerm = s_reg.lastTerm || wrEn;
    end else if (accept) begin
      s_next.lastTerm = termIn ? 1'b1 : (isDiscard ? s_reg.lastTerm : 1'b0);
      s_next.pendEoi = rxEoi && !isDiscard && !isTerm && !rxGet;
    end

    // a config answer about the last forwarded character
    if (s_reg.execValid && execIllegal) begin
      s_next.pendErr = 1'b1;
    end

    unique case (s_reg.state)
      EX_IDLE: begin
        if (rdEn) begin
          s_next.state = EX_FETCH;
        end
      end
      EX_FETCH: begin
        consume = 1'b1;
        isMark = (rdChar == `MARK_TERM) || (rdChar == `MARK_GET);
        s_next.state = EX_IDLE;
        if (rdChar == `MARK_GET || rdChar == `CHR_QMARK) begin
          if (s_reg.trigMode >= `TRIG_EXT_FIRST && s_reg.trigMode <= `TRIG_EXT_LAST) begin
            s_next.measReq = 1'b1;
            s_next.state = EX_MEAS;
            s_next.commitAfter = rdChar == `MARK_GET;
          end else if (rdChar == `CHR_QMARK) begin
            s_next.pendErr = 1'b1;
          end else begin
            commit = 1'b1;
          end
        end else if (rdChar == `MARK_TERM) begin
          commit = 1'b1;
        end else begin
          // everything else goes to the configuration engine in order
          s_next.execValid = 1'b1;
          s_next.execChar = rdChar;
          if (rdChar >= `CHR_ZERO && rdChar <= `CHR_NINE) begin
            if (s_reg.curLetter == `CHR_LETTER_T) begin
              if (rdChar <= `TRIG_DIGIT_LAST) begin
                s_next.trigMode = rdChar[2:0];
              end else begin
                s_next.pendErr = 1'b1;
              end
            end else if (s_reg.curLetter == `CHR_LETTER_G) begin
              if (rdChar <= `QUERY_DIGIT_LAST) begin
                s_next.pendStat = 1'b1;
                s_next.statVal = statusData;
              end else begin
                s_next.pendErr = 1'b1;
              end
            end
          end else begin
            s_next.curLetter = rdChar;
          end
        end
      end
      EX_MEAS: begin
        if (measDone) begin
          s_next.pendNum = 1'b1;
          s_next.numVal = measValue;
          s_next.state = EX_IDLE;
          s_next.commitAfter = 1'b0;
          commit = s_reg.commitAfter;
        end
      end
      default: begin
        // unused encoding, fall back to waiting for work
        s_next.state = EX_IDLE;
      end
    endcase

    if (consume) begin
      s_next.rdPtr = (s_reg.rdPtr == LAST) ? '0 : s_reg.rdPtr + 1'b1;
      cnt = cnt - 1'b1;
      if (isMark) begin
        tcnt = tcnt - 1'b1;
      end
    end
    s_next.count = cnt;
    s_next.termCount = tcnt;

    // hold off once full, release once complete strings are gone
    if (cnt == FULL) begin
      s_next.holdOff = 1'b1;
    end else if (tcnt == '0) begin
      s_next.holdOff = 1'b0;
    end

    // read or a new string drops the data; loads below win
    if (readDone || termIn) begin
      s_next.dataAvail = 1'b0;
    end
    if (termIn) begin
      s_next.anyError = 1'b0;
    end
    if (s_reg.trigMode == `TRIG_CONT && contReading && !talkBusy) begin
      s_next.outData = measValue;
      s_next.outIsError = 1'b0;
      s_next.dataAvail = 1'b1;
    end

    // whole string done: load at most one output, by priority
    // take this cycle's flags: a measurement ending a trigger marker
    // string must not miss its own load
    if (commit) begin
      pStat = s_next.pendStat;
      pErr = s_next.pendErr;
      pNum = s_next.pendNum;
      s_next.curLetter = '0;
      s_next.pendStat = 1'b0;
      s_next.pendNum = 1'b0;
      // status output leaves the error pending for the next string
      s_next.pendErr = pErr && pStat;
      if (pStat || pErr || pNum) begin
        s_next.dataAvail = 1'b1;
        s_next.anyError = pErr;
        s_next.outIsError = !pStat && pErr;
        if (pStat) begin
          s_next.outData = s_next.statVal;
        end else if (pErr) begin
          s_next.outData = `ERR_SYNTAX_CODE;
        end else begin
          s_next.outData = s_next.numVal;
        end
      end
    end

    // device clear empties the queue at once
    if (busClear) begin
      s_next.wrPtr = '0;
      s_next.rdPtr = '0;
      s_next.count = '0;
      s_next.termCount = '0;
      s_next.holdOff = 1'b0;
      s_next.lastTerm = 1'b0;
      s_next.pendEoi = 1'b0;
      s_next.state = EX_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register, statusSel from the memory read data
  assign execValid = s_reg.execValid;
  assign execChar = s_reg.execChar;
  assign trigMode = s_reg.trigMode;
  assign measReq = s_reg.measReq;
  assign statusSel = rdChar[3:0];
  assign outValid = s_reg.dataAvail;
  assign outData = s_reg.outData;
  assign outIsError = s_reg.outIsError;
  assign spollByte = {1'b0, s_reg.anyError, s_reg.dataAvail, 5'h00};
endmodule : bus_command_input_processor

`default_nettype wire

// ===== core/cmd_char_filter.sv
// classifies one received bus character
// assumes: purely combinational, fed by the accepted bus byte
`timescale 1ns/1ps
`default_nettype none
`include "cmd_input_cfg.svh"

module cmd_char_filter
  import cmd_input_pkg::*;
(
  input wire logic [7:0] rawChar,
  output logic isTerm,
  output logic isDiscard,
  output logic [7:0] normChar
);
  // CR and LF close a string; EOI and GET arrive on their own lines
  always_comb begin
    isTerm = (rawChar == `CHR_CR) || (rawChar == `CHR_LF);
    // spaces, commas and other control codes never reach the buffer
    isDiscard = (rawChar == `CHR_SPACE) || (rawChar == `CHR_COMMA) ||
      (rawChar < `CHR_SPACE) || (rawChar >= `CHR_DEL);
    // case fold so later compares see one spelling
    if (rawChar >= `CHR_LOW_A && rawChar <= `CHR_LOW_Z) begin
      normChar = rawChar & `CHR_CASE_MASK;
    end else begin
      normChar = rawChar; // digits, sign, point, upper case exponent kept as typed
    end
  end
endmodule : cmd_char_filter

`default_nettype wire

// ===== core/cmd_char_mem.sv
// circular store for the command input buffer
// assumes: one writer and one reader on core_clk; read data appear one cycle after rdEn
`timescale 1ns/1ps
`default_nettype none

module cmd_char_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 350,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  typedef struct packed {
    logic [WIDTH-1:0] rdData;
  } mem_state_t;

  logic [WIDTH-1:0] store [DEPTH];
  mem_state_t s_reg, s_next;

  // storage array needs no reset, only the read register does
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_comb begin
    s_next = s_reg;
    if (rdEn) begin
      s_next.rdData = store[rdAddr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdData = s_reg.rdData;
endmodule : cmd_char_mem

`default_nettype wire

// ===== shared/cmd_input_cfg.svh
// constants of the bus command input processor
// assumes: included by bare name from the package and the design modules
`ifndef CMD_INPUT_CFG_SVH
`define CMD_INPUT_CFG_SVH

`define CMD_BUF_DEPTH 350
`define CMD_CHAR_W 8
`define CMD_VAL_W 16
// character codes seen on the bus
`define CHR_CR 8'h0d
`define CHR_LF 8'h0a
`define CHR_SPACE 8'h20
`define CHR_COMMA 8'h2c
`define CHR_DEL 8'h7f
`define CHR_QMARK 8'h3f
`define CHR_ZERO 8'h30
`define CHR_NINE 8'h39
`define CHR_LOW_A 8'h61
`define CHR_LOW_Z 8'h7a
`define CHR_CASE_MASK 8'hdf
`define CHR_LETTER_T 8'h54
`define CHR_LETTER_G 8'h47
// markers held in the input buffer
`define MARK_TERM 8'h0a
`define MARK_GET 8'h01
// trigger modes and query range
`define TRIG_CONT 3'h0
`define TRIG_EXT_FIRST 3'h1
`define TRIG_EXT_LAST 3'h4
`define TRIG_DIGIT_LAST 8'h34
`define QUERY_DIGIT_LAST 8'h38
// serial poll byte layout
`define SPOLL_DAV_BIT 5
`define SPOLL_ERR_BIT 6
// value loaded for a rejected command
`define ERR_SYNTAX_CODE 16'h0047

`endif

// ===== shared/cmd_input_pkg.sv
// types of the bus command input processor
// assumes: constants come from cmd_input_cfg.svh
`include "cmd_input_cfg.svh"

package cmd_input_pkg;
  typedef enum logic [1:0] {
    EX_IDLE,
    EX_FETCH,
    EX_MEAS
  } exec_state_t;
endpackage : cmd_input_pkg

// ===== tb/bus_command_input_processor_asserts.sv
// port checker for the command input processor
// assumes: bound to the top module, single core_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "cmd_input_cfg.svh"

module bus_command_input_processor_asserts #(
  parameter int VW = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEoi,
  input wire logic rxGet,
  input wire logic rxReady,
  input wire logic execValid,
  input wire logic [7:0] execChar,
  input wire logic [2:0] trigMode,
  input wire logic measReq,
  input wire logic outValid,
  input wire logic [VW-1:0] outData,
  input wire logic outIsError,
  input wire logic readDone,
  input wire logic [7:0] spollByte
);
  // terminator taken from the bus this cycle
  logic termTaken;
  assign termTaken = rxReady && (rxGet || rxValid && (rxEoi || rxData == `CHR_CR ||
    rxData == `CHR_LF));

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_pollLayout;
    spollByte[`SPOLL_DAV_BIT] == outValid && spollByte[7] == 1'b0 && spollByte[4:0] == 5'h00;
  endproperty
  a_pollLayout: assert property (p_pollLayout) else $error("poll byte layout");
  property p_upperOnly;
    execValid |-> !(execChar >= `CHR_LOW_A && execChar <= `CHR_LOW_Z);
  endproperty
  a_upperOnly: assert property (p_upperOnly) else $error("lower case forwarded");
  property p_noFiller;
    execValid |-> execChar != `CHR_SPACE && execChar != `CHR_COMMA && execChar != `CHR_DEL;
  endproperty
  a_noFiller: assert property (p_noFiller) else $error("filler forwarded");
  // data available only drops after a read or a new terminator
  property p_availDrop;
    $fell(outValid) |-> $past(readDone) || $past(termTaken) || $past(termTaken, 2);
  endproperty
  a_availDrop: assert property (p_availDrop) else $error("output dropped");
  property p_trigOnlyExt;
    measReq |-> trigMode >= `TRIG_EXT_FIRST && trigMode <= `TRIG_EXT_LAST;
  endproperty
  a_trigOnlyExt: assert property (p_trigOnlyExt) else $error("trigger outside ext");
  property p_errValue;
    outValid && outIsError |-> outData == `ERR_SYNTAX_CODE;
  endproperty
  a_errValue: assert property (p_errValue) else $error("error value wrong");
  // an EOI-tagged character stores its terminator one cycle later
  property p_pollClear;
    termTaken |-> ##2 (!spollByte[`SPOLL_ERR_BIT] || outValid);
  endproperty
  a_pollClear: assert property (p_pollClear) else $error("poll not cleared");
  property p_eoiGap;
    rxValid && rxReady && rxEoi && rxData > 8'h20 && rxData < `CHR_DEL |=> !rxReady;
  endproperty
  a_eoiGap: assert property (p_eoiGap) else $error("no gap after eoi");
  property p_measPulse;
    measReq |=> !measReq;
  endproperty
  a_measPulse: assert property (p_measPulse) else $error("measure twice");
endmodule : bus_command_input_processor_asserts

bind bus_command_input_processor bus_command_input_processor_asserts #(.VW(VW)) u_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData), .rxEoi(rxEoi),
  .rxGet(rxGet), .rxReady(rxReady), .execValid(execValid), .execChar(execChar),
  .trigMode(trigMode), .measReq(measReq), .outValid(outValid), .outData(outData),
  .outIsError(outIsError), .readDone(readDone), .spollByte(spollByte));
`default_nettype wire

// ===== tb/bus_command_input_processor_tb_top.sv
// testbench of the command input processor with a small input buffer
// assumes: design files and bus_ctrl_model compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "cmd_input_cfg.svh"

module bus_command_input_processor_tb_top
  import cmd_input_pkg::*;
;
  localparam logic [15:0] STAT = 16'h1a5c;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxValid, rxEoi, rxGet, rxReady, readDone, execValid;
  logic execIllegal = 1'b0;
  logic measReq, outValid, outIsError;
  logic measDone = 1'b0;
  logic contReading = 1'b0;
  logic talkBusy = 1'b0;
  logic [7:0] rxData, execChar, spollByte;
  logic [2:0] trigMode;
  logic [3:0] statusSel;
  logic [15:0] measValue = 16'h0000;
  logic [15:0] outData, statusData;
  int failCount = 0, checks = 0, measWait = 0, measDelay = 2, measN = 0, n0;
  logic [7:0] execLog[$];

  always #2.5 core_clk = ~core_clk;

  bus_command_input_processor #(.DEPTH(8)) u_bus_command_input_processor (
    .core_clk(core_clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData), .rxEoi(rxEoi),
    .rxGet(rxGet), .rxReady(rxReady), .busClear(1'b0), .execValid(execValid),
    .execChar(execChar), .execIllegal(execIllegal), .trigMode(trigMode), .measReq(measReq),
    .measDone(measDone), .measValue(measValue), .contReading(contReading),
    .talkBusy(talkBusy), .statusSel(statusSel), .statusData(statusData), .outValid(outValid),
    .outData(outData), .outIsError(outIsError), .readDone(readDone), .spollByte(spollByte));

  // status engine stand-in echoes the selected query in the low nibble
  assign statusData = {STAT[15:4], statusSel};

  bus_ctrl_model u_bus_ctrl_model (.core_clk(core_clk), .rxReady(rxReady), .rxValid(rxValid),
    .rxData(rxData), .rxEoi(rxEoi), .rxGet(rxGet), .readDone(readDone));

  // measurement and config engine stand-ins; X plays an illegal command
  always @(negedge core_clk) begin
    measDone <= 1'b0;
    execIllegal <= execValid && execChar == 8'h58;
    if (execValid) execLog.push_back(execChar);
    if (measReq) measWait <= measDelay;
    else if (measWait == 1) begin
      measDone <= 1'b1;
      measValue <= measValue + 16'h0101;
      measN <= measN + 1;
      measWait <= 0;
    end else if (measWait > 1) measWait <= measWait - 1;
  end

  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check

  task check_str(input string got, input string exp, input string what);
    checks++;
    if (got != exp) begin
      failCount++;
      $display("CHECK FAILED %0t %s got %s", $time, what, got);
    end
  endtask : check_str

  // forwarded printable commands, trigger marks left out
  function automatic string logged();
    string s;
    s = "";
    foreach (execLog[i]) if (execLog[i] > 8'h20 && execLog[i] != `CHR_QMARK)
      s = $sformatf("%s%c", s, execLog[i]);
    return s;
  endfunction : logged

  task wait_out;
    for (int i = 0; i < 400 && outValid !== 1'b1; i++) @(negedge core_clk);
  endtask : wait_out

  // two cycles per entry, so six more cover the terminator
  task wait_log(input int n);
    for (int i = 0; i < 400 && execLog.size() < n; i++) @(negedge core_clk);
    repeat (6) @(negedge core_clk);
  endtask : wait_log

  task sc_filter;
    execLog.delete();
    u_bus_ctrl_model.put_str("f, 3\001\r\n", 1'b1);
    wait_log(2);
    check_str(logged(), "F3", "filtered command");
  endtask : sc_filter

  task sc_trigger;
    n0 = measN;
    u_bus_ctrl_model.put_str("T1??\n", 1'b0);
    wait_out;
    check(16'(trigMode), 16'h0001, "trigger mode");
    check(16'(measN - n0), 16'h0002, "measure count");
    check(outData, measValue, "last output kept");
    check(16'(spollByte), 16'h0020, "poll byte");
    u_bus_ctrl_model.read_out();
    check(16'(outValid), 16'h0000, "read clears");
    u_bus_ctrl_model.read_out();
    check(16'(outValid), 16'h0000, "second read empty");
  endtask : sc_trigger

  task sc_get;
    u_bus_ctrl_model.put_get();
    wait_out;
    check(outData, measValue, "get output");
    execLog.delete();
    u_bus_ctrl_model.put_str("F1", 1'b1);
    wait_log(2);
    check_str(logged(), "F1", "eoi terminates");
    check(16'(outValid), 16'h0000, "new string drops data");
    check(16'(spollByte), 16'h0000, "poll cleared");
  endtask : sc_get

  task sc_error;
    u_bus_ctrl_model.put_str("XG3\n", 1'b0);
    wait_out;
    check(outData, {STAT[15:4], 4'h3}, "query select");
    check(16'(outIsError), 16'h0000, "status wins");
    u_bus_ctrl_model.put_str("?\n", 1'b0);
    check(16'(spollByte), 16'h0000, "poll cleared by terminator");
    wait_out;
    check(outData, `ERR_SYNTAX_CODE, "error wins");
    check(16'(outIsError), 16'h0001, "error flagged");
    check(16'(spollByte), 16'h0060, "error poll");
  endtask : sc_error

  // continuous readings reload the output with no command between reads
  task sc_cont;
    u_bus_ctrl_model.put_str("T0\n", 1'b0);
    repeat (12) @(negedge core_clk);
    check(16'(trigMode), 16'h0000, "continuous mode");
    talkBusy = 1'b1;
    contReading = 1'b1;
    @(negedge core_clk);
    check(16'(outValid), 16'h0000, "busy talker keeps output");
    talkBusy = 1'b0;
    @(negedge core_clk);
    contReading = 1'b0;
    check(16'(outValid), 16'h0001, "continuous load");
    check(outData, measValue, "continuous reading");
    u_bus_ctrl_model.read_out();
    check(16'(outValid), 16'h0000, "continuous read clears");
    contReading = 1'b1;
    @(negedge core_clk);
    contReading = 1'b0;
    check(16'(outValid), 16'h0001, "reading again");
  endtask : sc_cont

  // a slow measurement keeps the first string busy so the buffer fills
  task sc_holdoff;
    measDelay = 60;
    n0 = u_bus_ctrl_model.stallCount;
    execLog.delete();
    u_bus_ctrl_model.put_str("T1?\nFFFFFFFFF\n", 1'b0);
    wait_log(11);
    check_str(logged(), "T1FFFFFFFFF", "nothing lost");
    check(16'(u_bus_ctrl_model.stallCount > n0), 16'h0001, "held off");
    measDelay = 2;
  endtask : sc_holdoff

  task finish_test;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge core_clk);
    failCount++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    sc_filter();
    sc_trigger();
    sc_get();
    sc_error();
    sc_holdoff();
    sc_cont();
    finish_test();
  end
endmodule : bus_command_input_processor_tb_top
`default_nettype wire

// ===== tb/bus_ctrl_model.sv
// bus controller stand-in: sends strings and GET, reads output
// assumes: inputs change at falling edges, taken at rising edge with rxReady
`timescale 1ns/1ps
`default_nettype none

module bus_ctrl_model (
  input wire logic core_clk,
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxEoi,
  output logic rxGet,
  output logic readDone
);
  int stallCount;

  initial begin
    rxValid = 1'b0;
    rxData = 8'hff;
    rxEoi = 1'b0;
    rxGet = 1'b0;
    readDone = 1'b0;
    stallCount = 0;
  end

  // bytes back to back; held until taken, eoi rides on the last one
  task put_str(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge core_clk);
      rxValid = 1'b1;
      rxData = s[i];
      rxEoi = eoi && i == s.len() - 1;
      while (!rxReady) begin
        stallCount++;
        @(negedge core_clk);
      end
      @(posedge core_clk);
    end
    @(negedge core_clk);
    rxValid = 1'b0;
    rxEoi = 1'b0;
    rxData = ~rxData; // released lines never show the old byte
  endtask : put_str

  task put_get;
    @(negedge core_clk);
    rxGet = 1'b1;
    while (!rxReady) @(negedge core_clk);
    @(posedge core_clk);
    @(negedge core_clk);
    rxGet = 1'b0;
  endtask : put_get

  // one finished read of the output buffer
  task read_out;
    @(negedge core_clk);
    readDone = 1'b1;
    @(negedge core_clk);
    readDone = 1'b0;
  endtask : read_out
endmodule : bus_ctrl_model
`default_nettype wire
